//--- src/fpp_map.vh
// Constants for the flash programming-port controller
`ifndef FPP_MAP_VH
`define FPP_MAP_VH
`define FPP_CMD_READ 8'h00
`define FPP_CMD_ERASE 8'h20
`define FPP_CMD_AUTOERASE 8'h30
`define FPP_CMD_PROGRAM 8'h40
`define FPP_CMD_ERASE_VERIFY 8'hA0
`define FPP_CMD_PROGRAM_VERIFY 8'hC0
`define FPP_CMD_RESET 8'hFF
`define FPP_ERASED_BYTE 8'hFF
`define FPP_OP_READ 3'h0
`define FPP_OP_PROGRAM 3'h1
`define FPP_OP_ERASE 3'h2
`define FPP_OP_AUTOERASE 3'h3
`define FPP_OP_RESET 3'h4
`define FPP_OP_ERASE_VERIFY 3'h5
`define FPP_OP_PROGRAM_VERIFY 3'h6
`define FPP_CLK_MHZ 20
`define FPP_T_VPS_NS 100
`define FPP_T_WEP_NS 70
`define FPP_T_WEH_NS 40
`define FPP_T_DS_NS 50
`define FPP_T_AH_NS 60
`define FPP_T_OERS_NS 6000
`define FPP_T_VA_NS 500
`define FPP_T_PPW_NS 25000
`define FPP_T_ET_NS 9000000
`define FPP_T_AET_NS 30000000
`endif

//--- src/fpp_host.v
// External programmer that drives the flash programming-port strobes
`timescale 1ns/100ps
`include "fpp_map.vh"
// What the document requires of the part and its programmer
// RULE_01: On-board software masks all interrupts while program or erase bits are set.
// RULE_02: With supply-level voltage pin, strobes select read, output disable or standby.
// RULE_03: Command bytes are written only at high voltage, CE low, OE high, WE low.
// RULE_04: Memory read is one write of 00, then reads at the fetch location.
// RULE_05: Erase 20, auto-erase 30 and reset FF are written twice at any address.
// RULE_06: Erase verify writes A0 at the location, next read returns check result.
// RULE_07: Program writes 40, then a second write of target location and byte.
// RULE_08: Program verify writes C0, next read returns result of last programmed byte.
// RULE_09: Unprogrammed locations read back as all ones.
// RULE_10: The part gives no identity code; its type is told by other means.
// RULE_11: The device offers a separate mode for external program, erase and verify.
// RULE_12: After programming, wait, verify and retry programming up to a bounded count.
module fpp_host #(
    parameter MAX_RETRY = 25,
    parameter PPW_CYC = ((`FPP_T_PPW_NS * `FPP_CLK_MHZ) + 999) / 1000,
    parameter ET_CYC = ((`FPP_T_ET_NS / 1000) * `FPP_CLK_MHZ),
    parameter AET_CYC = ((`FPP_T_AET_NS / 1000) * `FPP_CLK_MHZ),
    parameter OERS_CYC = ((`FPP_T_OERS_NS * `FPP_CLK_MHZ) + 999) / 1000
) (
    input wire core_clk,
    input wire sys_rst,
    input wire req_valid,
    input wire [2:0] req_op,
    input wire [16:0] req_addr,
    input wire [7:0] req_data,
    output reg req_ready_ff,
    output reg rsp_valid_ff,
    output reg [7:0] rsp_data_ff,
    output reg rsp_fail_ff,
    output reg chip_en_n_ff,
    output reg out_en_n_ff,
    output reg wr_en_n_ff,
    output reg programming_voltage_pin_ff,
    output reg [16:0] addr_ff,
    output reg [7:0] data_out_ff,
    output reg data_oe_ff,
    input wire [7:0] data_in
);
    // ****************************************
    // Timing counts
    // ****************************************
    localparam VPS_CYC = ((`FPP_T_VPS_NS * `FPP_CLK_MHZ) + 999) / 1000;
    localparam WEP_CYC = ((`FPP_T_WEP_NS * `FPP_CLK_MHZ) + 999) / 1000;
    localparam WEH_CYC = ((`FPP_T_WEH_NS * `FPP_CLK_MHZ) + 999) / 1000;
    localparam VA_CYC = ((`FPP_T_VA_NS * `FPP_CLK_MHZ) + 999) / 1000 + 1;
    localparam S_IDLE = 4'h0;
    localparam S_VPS = 4'h1;
    localparam S_WLOW = 4'h2;
    localparam S_WHIGH = 4'h3;
    localparam S_WAIT = 4'h4;
    localparam S_RLOW = 4'h5;
    localparam S_DONE = 4'h6;
    localparam S_VDROP = 4'h7;
    reg [3:0] state_ff;
    reg [31:0] cnt_ff;
    reg [1:0] cyc_ff;
    reg [2:0] op_ff;
    reg [16:0] loc_ff;
    reg [7:0] byte_ff;
    reg [7:0] tries_ff;
    reg [1:0] sync_cnt_ff;
    reg [7:0] din_meta_ff;
    reg [7:0] din_ff;

    // Number of write cycles before the read (or end) for each operation
    function [1:0] fpp_writes;
        input [2:0] op;
        begin
            case (op)
                `FPP_OP_READ, `FPP_OP_ERASE_VERIFY, `FPP_OP_PROGRAM_VERIFY: fpp_writes = 2'h1;
                default: fpp_writes = 2'h2;
            endcase
        end
    endfunction

    // Command byte for the first write; there is no identity-read command
    function [7:0] fpp_cmd; // RULE_10
        input [2:0] op;
        begin
            case (op)
                `FPP_OP_READ: fpp_cmd = `FPP_CMD_READ; // RULE_04
                `FPP_OP_PROGRAM: fpp_cmd = `FPP_CMD_PROGRAM; // RULE_07
                `FPP_OP_ERASE: fpp_cmd = `FPP_CMD_ERASE; // RULE_05
                `FPP_OP_AUTOERASE: fpp_cmd = `FPP_CMD_AUTOERASE; // RULE_05
                `FPP_OP_ERASE_VERIFY: fpp_cmd = `FPP_CMD_ERASE_VERIFY; // RULE_06
                `FPP_OP_PROGRAM_VERIFY: fpp_cmd = `FPP_CMD_PROGRAM_VERIFY; // RULE_08
                default: fpp_cmd = `FPP_CMD_RESET; // RULE_05
            endcase
        end
    endfunction

    function fpp_has_read;
        input [2:0] op;
        begin
            fpp_has_read = (fpp_writes(op) == 2'h1);
        end
    endfunction

    // ****************************************
    // Read data synchroniser
    // ****************************************
    always @(posedge core_clk)
    begin
        din_meta_ff <= data_in;
        din_ff <= din_meta_ff;
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state_ff <= S_IDLE;
            cnt_ff <= 32'h0;
            cyc_ff <= 2'h0;
            op_ff <= 3'h0;
            loc_ff <= 17'h0;
            byte_ff <= 8'h0;
            tries_ff <= 8'h0;
            sync_cnt_ff <= 2'h0;
            req_ready_ff <= 1'b0;
            rsp_valid_ff <= 1'b0;
            rsp_data_ff <= 8'h0;
            rsp_fail_ff <= 1'b0;
            chip_en_n_ff <= 1'b1;
            out_en_n_ff <= 1'b1;
            wr_en_n_ff <= 1'b1;
            programming_voltage_pin_ff <= 1'b0;
            addr_ff <= 17'h0;
            data_out_ff <= 8'h0;
            data_oe_ff <= 1'b0;
        end
        else
        begin
            rsp_valid_ff <= 1'b0;
            case (state_ff)
                S_IDLE:
                begin
                    req_ready_ff <= 1'b1;
                    if (req_valid && req_ready_ff)
                    begin
                        req_ready_ff <= 1'b0;
                        op_ff <= req_op;
                        loc_ff <= req_addr;
                        byte_ff <= req_data;
                        tries_ff <= 8'h0;
                        cyc_ff <= 2'h0;
                        // Strobes stay high while the voltage level changes
                        programming_voltage_pin_ff <= 1'b1; // RULE_11
                        cnt_ff <= VPS_CYC;
                        state_ff <= S_VPS;
                    end
                end
                S_VPS:
                begin
                    if (cnt_ff > 32'h1)
                        cnt_ff <= cnt_ff - 32'h1;
                    else
                    begin
                        // Write strobe: CE low, OE high, WE low, data driven
                        chip_en_n_ff <= 1'b0; // RULE_03
                        out_en_n_ff <= 1'b1;
                        wr_en_n_ff <= 1'b0;
                        data_oe_ff <= 1'b1;
                        if (cyc_ff == 2'h0)
                        begin
                            data_out_ff <= fpp_cmd(op_ff);
                            addr_ff <= loc_ff; // RULE_06
                        end
                        else if (op_ff == `FPP_OP_PROGRAM)
                        begin
                            data_out_ff <= byte_ff; // RULE_07
                            addr_ff <= loc_ff;
                        end
                        else
                            data_out_ff <= fpp_cmd(op_ff); // RULE_05
                        cnt_ff <= (WEP_CYC > `FPP_T_DS_NS / 50) ? WEP_CYC : 1;
                        state_ff <= S_WLOW;
                    end
                end
                S_WLOW:
                begin
                    if (cnt_ff > 32'h1)
                        cnt_ff <= cnt_ff - 32'h1;
                    else
                    begin
                        wr_en_n_ff <= 1'b1;
                        // Data and address held one more phase covers hold times
                        cnt_ff <= WEH_CYC + ((`FPP_T_AH_NS * `FPP_CLK_MHZ) + 999) / 1000;
                        cyc_ff <= cyc_ff + 2'h1;
                        state_ff <= S_WHIGH;
                    end
                end
                S_WHIGH:
                begin
                    if (cnt_ff > 32'h1)
                        cnt_ff <= cnt_ff - 32'h1;
                    else if (cyc_ff < fpp_writes(op_ff))
                    begin
                        cnt_ff <= 32'h1;
                        state_ff <= S_VPS;
                    end
                    else
                    begin
                        data_oe_ff <= 1'b0;
                        chip_en_n_ff <= 1'b1;
                        state_ff <= S_WAIT;
                        if (op_ff == `FPP_OP_PROGRAM)
                            cnt_ff <= PPW_CYC; // RULE_12
                        else if (op_ff == `FPP_OP_ERASE)
                            cnt_ff <= ET_CYC;
                        else if (op_ff == `FPP_OP_AUTOERASE)
                            cnt_ff <= AET_CYC;
                        else if (op_ff == `FPP_OP_READ)
                            cnt_ff <= 32'h1;
                        else
                            cnt_ff <= OERS_CYC;
                    end
                end
                S_WAIT:
                begin
                    if (cnt_ff > 32'h1)
                        cnt_ff <= cnt_ff - 32'h1;
                    else if (op_ff == `FPP_OP_PROGRAM)
                    begin
                        // Verify the byte just programmed before reporting
                        op_ff <= `FPP_OP_PROGRAM_VERIFY; // RULE_12
                        cyc_ff <= 2'h0;
                        tries_ff <= tries_ff + 8'h1;
                        cnt_ff <= 32'h1;
                        state_ff <= S_VPS;
                    end
                    else if (fpp_has_read(op_ff))
                    begin
                        // Read strobe: CE low, OE low, WE high
                        chip_en_n_ff <= 1'b0; // RULE_02
                        out_en_n_ff <= 1'b0;
                        addr_ff <= loc_ff; // RULE_04
                        cnt_ff <= VA_CYC + 2;
                        state_ff <= S_RLOW;
                    end
                    else
                    begin
                        rsp_data_ff <= 8'h0;
                        rsp_fail_ff <= 1'b0;
                        state_ff <= S_DONE;
                    end
                end
                S_RLOW:
                begin
                    if (cnt_ff > 32'h1)
                        cnt_ff <= cnt_ff - 32'h1;
                    else
                    begin
                        out_en_n_ff <= 1'b1;
                        chip_en_n_ff <= 1'b1;
                        rsp_data_ff <= din_ff;
                        rsp_fail_ff <= 1'b0;
                        state_ff <= S_DONE;
                        // Retry loop only when this verify follows our own program
                        if (op_ff == `FPP_OP_PROGRAM_VERIFY && tries_ff != 8'h0 && din_ff != byte_ff)
                        begin
                            if ({24'h0, tries_ff} < MAX_RETRY)
                            begin
                                op_ff <= `FPP_OP_PROGRAM; // RULE_12
                                cyc_ff <= 2'h0;
                                cnt_ff <= 32'h1;
                                state_ff <= S_VPS;
                            end
                            else
                                rsp_fail_ff <= 1'b1;
                        end
                    end
                end
                S_DONE:
                begin
                    // Back to supply level with strobes high before the next job
                    programming_voltage_pin_ff <= 1'b0; // RULE_02
                    cnt_ff <= VPS_CYC;
                    rsp_valid_ff <= 1'b1; // RULE_01
                    state_ff <= S_VDROP;
                end
                S_VDROP:
                begin
                    if (cnt_ff > 32'h1)
                        cnt_ff <= cnt_ff - 32'h1;
                    else
                        state_ff <= S_IDLE;
                end
                default:
                    state_ff <= S_IDLE;
            endcase
        end
    end
endmodule // fpp_host

//--- tb/fpp_host_chk.sv
// Port-level assertions for the flash programming-port controller
`timescale 1ns/100ps
module fpp_host_chk (
    input wire core_clk,
    input wire sys_rst,
    input wire req_valid,
    input wire req_ready_ff,
    input wire rsp_valid_ff,
    input wire rsp_fail_ff,
    input wire chip_en_n_ff,
    input wire out_en_n_ff,
    input wire wr_en_n_ff,
    input wire programming_voltage_pin_ff,
    input wire [16:0] addr_ff,
    input wire [7:0] data_out_ff,
    input wire data_oe_ff
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // ****************
    // Pin protocol
    // ****************
    wr_state_a: assert property (!wr_en_n_ff |-> out_en_n_ff && !chip_en_n_ff && programming_voltage_pin_ff && data_oe_ff)
        else $error("write strobe outside command-write state");
    wr_pulse_a: assert property ($fell(wr_en_n_ff) |-> ##1 !wr_en_n_ff ##1 wr_en_n_ff[*3])
        else $error("write pulse shape wrong");
    wr_setup_a: assert property (!wr_en_n_ff && $past(!wr_en_n_ff) |-> $stable(data_out_ff) && $stable(addr_ff))
        else $error("data or address moved during write");
    wr_hold_a: assert property ($rose(wr_en_n_ff) |-> $stable(addr_ff) && data_oe_ff)
        else $error("no hold after write strobe");
    rd_nodrive_a: assert property (!out_en_n_ff |-> !data_oe_ff && wr_en_n_ff)
        else $error("host drives data while reading");
    rd_len_a: assert property ($fell(out_en_n_ff) |-> (!out_en_n_ff && !chip_en_n_ff)[*8])
        else $error("read strobe too short");
    vpp_quiet_a: assert property ($changed(programming_voltage_pin_ff) |-> chip_en_n_ff && out_en_n_ff && wr_en_n_ff)
        else $error("voltage moved with strobes active");
    take_drop_a: assert property (req_valid && req_ready_ff |=> !req_ready_ff)
        else $error("ready held after take");
    rsp_back_a: assert property (rsp_valid_ff |=> !rsp_valid_ff ##[0:7] req_ready_ff)
        else $error("response not a pulse or ready late");
    c_fail: cover property (rsp_valid_ff && rsp_fail_ff);
    c_wr: cover property ($fell(wr_en_n_ff));
    c_rd: cover property ($fell(out_en_n_ff));
endmodule // fpp_host_chk

//--- tb/fpp_dev_model.sv
// Behavioural flash device behind the programming-port pins
`timescale 1ns/100ps
`include "fpp_map.vh"
module fpp_dev_model #(
    parameter ACC_NS = 400
) (
    input wire chip_en_n,
    input wire out_en_n,
    input wire wr_en_n,
    input wire vpp_high,
    input wire [16:0] addr,
    input wire [7:0] din,
    input wire prog_weak,
    output wire [7:0] dq
);
    reg [7:0] mem [0:131071];
    reg [7:0] first_ff;
    reg pend_ff;
    reg [2:0] mode_ff;
    reg [16:0] ev_loc_ff;
    reg [16:0] prog_loc_ff;
    reg [7:0] last_q;
    integer i;
    wire drive = !chip_en_n && !out_en_n && wr_en_n;
    wire [7:0] rd_byte = (mode_ff == `FPP_OP_ERASE_VERIFY) ? mem[ev_loc_ff] :
        (mode_ff == `FPP_OP_PROGRAM_VERIFY) ? mem[prog_loc_ff] : mem[addr];
    // Released bus shows the inverse, so a stale byte can never pass a compare
    assign #(ACC_NS) dq = drive ? rd_byte : ~last_q;
    always @*
        if (drive)
            last_q = rd_byte;
    // No identity readout; only read, program, erase, verify and reset exist here
    initial
    begin
        for (i = 0; i < 131072; i = i + 1)
            mem[i] = `FPP_ERASED_BYTE;
        pend_ff = 1'b0;
        mode_ff = `FPP_OP_READ;
        last_q = 8'h00;
    end
    always @(posedge wr_en_n)
        if (vpp_high && !chip_en_n && out_en_n)
        begin
            if (!pend_ff)
            begin
                first_ff = din;
                pend_ff = din == `FPP_CMD_ERASE || din == `FPP_CMD_AUTOERASE || din == `FPP_CMD_PROGRAM
                    || din == `FPP_CMD_RESET;
                if (din == `FPP_CMD_READ)
                    mode_ff = `FPP_OP_READ;
                if (din == `FPP_CMD_ERASE_VERIFY)
                begin
                    mode_ff = `FPP_OP_ERASE_VERIFY;
                    ev_loc_ff = addr;
                end
                if (din == `FPP_CMD_PROGRAM_VERIFY)
                    mode_ff = `FPP_OP_PROGRAM_VERIFY;
            end
            else
            begin
                pend_ff = 1'b0;
                mode_ff = `FPP_OP_READ;
                if (first_ff == `FPP_CMD_PROGRAM)
                begin
                    mem[addr] = prog_weak ? din ^ 8'h01 : din;
                    prog_loc_ff = addr;
                end
                else if (din == first_ff && first_ff != `FPP_CMD_RESET)
                    for (i = 0; i < 131072; i = i + 1)
                        mem[i] = `FPP_ERASED_BYTE;
            end
        end
endmodule // fpp_dev_model

//--- tb/fpp_host_test.sv
// Self-checking bench for the flash programming-port controller
`timescale 1ns/100ps
`include "fpp_map.vh"
module fpp_host_test;
    reg core_clk = 0;
    reg sys_rst = 1;
    reg req_valid = 0;
    reg [2:0] req_op = 0;
    reg [16:0] req_addr = 0;
    reg [7:0] req_data = 0;
    reg prog_weak = 0;
    wire req_ready_ff, rsp_valid_ff, rsp_fail_ff, chip_en_n_ff, out_en_n_ff, wr_en_n_ff, vpp, data_oe_ff;
    wire [7:0] rsp_data_ff, data_out_ff, dev_q, data_in;
    wire [16:0] addr_ff;
    integer err_total = 0;
    integer n_checks = 0;
    assign data_in = data_oe_ff ? data_out_ff : dev_q;
    fpp_host #(.MAX_RETRY(3), .PPW_CYC(4), .ET_CYC(4), .AET_CYC(4), .OERS_CYC(4)) DUT (.core_clk(core_clk),
        .sys_rst(sys_rst), .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
        .req_ready_ff(req_ready_ff), .rsp_valid_ff(rsp_valid_ff), .rsp_data_ff(rsp_data_ff),
        .rsp_fail_ff(rsp_fail_ff), .chip_en_n_ff(chip_en_n_ff), .out_en_n_ff(out_en_n_ff), .wr_en_n_ff(wr_en_n_ff),
        .programming_voltage_pin_ff(vpp), .addr_ff(addr_ff), .data_out_ff(data_out_ff), .data_oe_ff(data_oe_ff),
        .data_in(data_in));
    fpp_dev_model flash (.chip_en_n(chip_en_n_ff), .out_en_n(out_en_n_ff), .wr_en_n(wr_en_n_ff),
        .vpp_high(vpp), .addr(addr_ff), .din(data_out_ff), .prog_weak(prog_weak), .dq(dev_q));
    initial
        forever #25 core_clk = ~core_clk;
    // ****************
    // Shared tasks
    // ****************
    task give_verdict;
    begin
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    task chk_byte(input [8*8-1:0] what, input [7:0] exp, input [7:0] got);
    begin
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            $display("BAD %0s expected %h seen %h", what, exp, got);
            err_total = err_total + 1;
        end
    end
    endtask
    task chk_bit(input [8*8-1:0] what, input exp, input got);
    begin
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            $display("BAD %0s expected %b seen %b", what, exp, got);
            err_total = err_total + 1;
        end
    end
    endtask
    // Waits are bounded so a stuck handshake shows up as a mismatch
    task run_job(input [2:0] op, input [16:0] loc, input [7:0] byt);
        integer n;
    begin
        @(negedge core_clk);
        req_op = op;
        req_addr = loc;
        req_data = byt;
        req_valid = 1;
        n = 0;
        // Ready is judged at the falling edge, where it has settled
        while (req_ready_ff !== 1'b1 && n < 100)
        begin
            @(negedge core_clk);
            n = n + 1;
        end
        // The rising edge in between has taken the request
        @(negedge core_clk);
        req_valid = 0;
        chk_bit("taken", 1'b0, req_ready_ff);
        n = 0;
        while (rsp_valid_ff !== 1'b1 && n < 5000)
        begin
            @(negedge core_clk);
            n = n + 1;
        end
        chk_bit("answer", 1'b1, rsp_valid_ff);
    end
    endtask
    task t_mid_reset;
        integer n;
    begin
        @(negedge core_clk);
        req_op = `FPP_OP_PROGRAM;
        req_addr = 17'h00040;
        req_data = 8'hA5;
        req_valid = 1;
        n = 0;
        while (req_ready_ff !== 1'b1 && n < 100)
        begin
            @(negedge core_clk);
            n = n + 1;
        end
        @(negedge core_clk);
        req_valid = 0;
        chk_bit("vpp up", 1'b1, vpp);
        // Reset lands while the voltage settles, before any write reaches the part
        sys_rst = 1;
        @(negedge core_clk);
        chk_bit("rst ce", 1'b1, chip_en_n_ff);
        chk_bit("rst vpp", 1'b0, vpp);
        chk_bit("rst rdy", 1'b0, req_ready_ff);
        @(negedge core_clk);
        sys_rst = 0;
        @(negedge core_clk);
        chk_bit("rel rdy", 1'b1, req_ready_ff);
        run_job(`FPP_OP_READ, 17'h00040, 8'h00);
        chk_byte("unwritn", `FPP_ERASED_BYTE, rsp_data_ff);
    end
    endtask
    // ****************
    // Scenarios
    // ****************
    task t_blank;
    begin
        chk_bit("idle ce", 1'b1, chip_en_n_ff);
        chk_bit("idle vpp", 1'b0, vpp);
        run_job(`FPP_OP_READ, 17'h1FFFF, 8'h00);
        chk_byte("blank", `FPP_ERASED_BYTE, rsp_data_ff);
    end
    endtask
    task t_program;
    begin
        run_job(`FPP_OP_PROGRAM, 17'h00010, 8'h5A);
        chk_bit("pfail", 1'b0, rsp_fail_ff);
        run_job(`FPP_OP_READ, 17'h00010, 8'h00);
        chk_byte("readbk", 8'h5A, rsp_data_ff);
        run_job(`FPP_OP_PROGRAM_VERIFY, 17'h00000, 8'h00);
        chk_byte("pverify", 8'h5A, rsp_data_ff);
        run_job(`FPP_OP_ERASE_VERIFY, 17'h00010, 8'h00);
        chk_byte("everify", 8'h5A, rsp_data_ff);
        run_job(`FPP_OP_READ, 17'h00011, 8'h00);
        chk_byte("neighbr", 8'hFF, rsp_data_ff);
    end
    endtask
    task t_erase(input [2:0] op);
    begin
        run_job(`FPP_OP_PROGRAM, 17'h00020, 8'h3C);
        run_job(op, 17'h00000, 8'h00);
        run_job(`FPP_OP_READ, 17'h00020, 8'h00);
        chk_byte("erased", 8'hFF, rsp_data_ff);
    end
    endtask
    task t_reset_keep;
    begin
        run_job(`FPP_OP_PROGRAM, 17'h10000, 8'hC3);
        run_job(`FPP_OP_RESET, 17'h00000, 8'h00);
        run_job(`FPP_OP_READ, 17'h10000, 8'h00);
        chk_byte("kept", 8'hC3, rsp_data_ff);
    end
    endtask
    task t_retry_fail;
    begin
        prog_weak = 1;
        run_job(`FPP_OP_PROGRAM, 17'h00030, 8'h0F);
        chk_bit("pfail", 1'b1, rsp_fail_ff);
        prog_weak = 0;
        run_job(`FPP_OP_READ, 17'h00030, 8'h00);
        chk_byte("weak", 8'h0E, rsp_data_ff);
    end
    endtask
    initial
    begin
        #(50 * 60000);
        err_total = err_total + 1;
        give_verdict;
    end
    initial
    begin
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        sys_rst = 0;
        t_blank;
        t_program;
        t_erase(`FPP_OP_ERASE);
        t_erase(`FPP_OP_AUTOERASE);
        t_reset_keep;
        t_retry_fail;
        t_mid_reset;
        give_verdict;
    end
endmodule // fpp_host_test
bind fpp_host fpp_host_chk CHK (.core_clk(core_clk), .sys_rst(sys_rst), .req_valid(req_valid),
    .req_ready_ff(req_ready_ff), .rsp_valid_ff(rsp_valid_ff), .rsp_fail_ff(rsp_fail_ff),
    .chip_en_n_ff(chip_en_n_ff), .out_en_n_ff(out_en_n_ff), .wr_en_n_ff(wr_en_n_ff),
    .programming_voltage_pin_ff(programming_voltage_pin_ff), .addr_ff(addr_ff), .data_out_ff(data_out_ff),
    .data_oe_ff(data_oe_ff));
